//--- rtl/dilx_consts.vh
// Constants for the DS1 idle/loopback select and DS2 X-bit status block
`ifndef DILX_CONSTS_VH
`define DILX_CONSTS_VH
// ==========================================
// Register indices; one aligned word each, byte address is four times the index
`define DILX_IDX_IDLE_CODE   8'h02
`define DILX_IDX_XBIT_STAT   8'h14
`define DILX_IDX_LOOP_CODE   8'h1E
// Register byte addresses
`define DILX_OFF_IDLE_CODE   8'h08
`define DILX_OFF_IDLE_SEL    8'h38
`define DILX_OFF_XBIT_STAT   8'h50
`define DILX_OFF_LOOP_CODE   8'h78
`define DILX_OFF_LOOP_MAP    8'h3C
// ==========================================
// Field positions
`define DILX_IDLE_LO_BIT     0
`define DILX_IDLE_HI_BIT     1
`define DILX_XBIT_MSB        6
`define DILX_NUM_CH          4
// ==========================================
// Reset values
`define DILX_RST_IDLE_CODE   2'h0
`define DILX_RST_IDLE_SEL    4'h0
`define DILX_RST_LOOP_MAP    4'h0
`define DILX_RST_LOOP_CODE   8'h00
// ==========================================
// Fifo
`define DILX_FIFO_DEPTH      16
`define DILX_FIFO_AW         4
`endif

//--- rtl/dilx_top.v
// DS1 transmit source select, idle pattern, loopback and DS2 X-bit status
// Each register is one aligned 32-bit word; the byte address is four
// times the register index, so index 1E sits at byte address 78.
// Data sits in the low bits of the word, upper bits read zero.
//
// All line inputs come from outside the clock domain and pass two
// flip-flops before the source select reads them. The transmit path
// therefore lags its chosen input by three clock cycles in total.
//
// The received X-bits are queued on every change so that a reader
// does not miss a short change between two register reads. A change
// that meets a full queue sets a sticky overflow flag; a write to the
// X-bit status word clears it, but a new overflow in the same cycle
// wins over the clear.
`timescale 1ns/100ps
`include "dilx_consts.vh"
`default_nettype none

// ==========================================
// Synchronous FIFO with valid/ready on both sides
module dilx_fifo #(
   parameter W  = 8,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire [W-1:0]  in_data,
   input  wire          in_valid,
   output wire          in_ready,
   output wire [W-1:0]  out_data,
   output wire          out_valid,
   input  wire          out_ready
);
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   reg [AW:0]   cnt_reg;
   wire         push;
   wire         pop;

   // Fill level that marks the queue as full, at the width of the count
   localparam [AW:0] FULL_LVL = D;

   // Honest full and empty from the fill count
   // The count is one bit wider than the pointers, so full and empty
   // never alias when the pointers meet.
   assign in_ready  = (cnt_reg != FULL_LVL);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data  = mem[rp_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage write
   always @(posedge pclk) begin
      if (push) begin
         mem[wp_reg] <= in_data;
      end
   end

   // Pointers and count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_reg  <= {AW{1'b0}};
         rp_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
         if (push & ~pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop & ~push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// ==========================================
// Register bank and per-channel transmit source select
module dilx_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [3:0]  ds1_tx_data_in,
   input  wire [3:0]  ds1_tx_clock_in,
   input  wire [3:0]  ds1_rx_data_in,
   input  wire [3:0]  ds1_rx_clock_in,
   input  wire [3:0]  idle_data_in,
   input  wire [3:0]  idle_clock_in,
   input  wire [6:0]  rx_ds2_xbit_in,
   output reg  [1:0]  idle_code_sel,
   output reg  [7:0]  loop_code,
   output reg  [3:0]  ds1_tx_data_out,
   output reg  [3:0]  ds1_tx_clock_out,
   output wire [7:0]  fifo_data,
   output wire        fifo_valid,
   input  wire        fifo_ready,
   output reg         fifo_overflow
);
   localparam N = `DILX_NUM_CH;

   reg  [N-1:0] channel_idle_select_reg;
   reg  [N-1:0] loop_map_reg;
   reg  [6:0]   xs1_reg;
   reg  [6:0]   rx_ds2_xbit_state_reg;
   reg  [N-1:0] s1_reg [0:5];
   reg  [N-1:0] s2_reg [0:5];
   wire [N-1:0] dat_next;
   wire [N-1:0] clk_next;
   reg  [7:0]   xbit_prev_reg;
   wire         acc;
   wire         wr;
   wire         rd;
   wire         hit;
   wire         xb_in_ready;
   wire [7:0]   xbit_word;
   integer      k;
   genvar       g;

   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;
   assign hit = (paddr == `DILX_OFF_IDLE_CODE) | (paddr == `DILX_OFF_IDLE_SEL) |
                (paddr == `DILX_OFF_XBIT_STAT) | (paddr == `DILX_OFF_LOOP_CODE) |
                (paddr == `DILX_OFF_LOOP_MAP);
   // Bit 7 reads zero; bits 6..0 are live X-bits
   assign xbit_word = {1'b0, rx_ds2_xbit_state_reg};

   // Two-flop synchronisers for the pin inputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (k = 0; k < 6; k = k + 1) begin
            s1_reg[k] <= {N{1'b0}};
            s2_reg[k] <= {N{1'b0}};
         end
         xs1_reg               <= 7'h00;
         rx_ds2_xbit_state_reg <= 7'h00;
      end else begin
         s1_reg[0] <= ds1_tx_data_in;
         s1_reg[1] <= ds1_tx_clock_in;
         s1_reg[2] <= ds1_rx_data_in;
         s1_reg[3] <= ds1_rx_clock_in;
         s1_reg[4] <= idle_data_in;
         s1_reg[5] <= idle_clock_in;
         for (k = 0; k < 6; k = k + 1) begin
            s2_reg[k] <= s1_reg[k];
         end
         xs1_reg               <= rx_ds2_xbit_in;
         rx_ds2_xbit_state_reg <= xs1_reg;
      end
   end

   // APB register writes, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_code_sel           <= `DILX_RST_IDLE_CODE;
         channel_idle_select_reg <= `DILX_RST_IDLE_SEL;
         loop_map_reg            <= `DILX_RST_LOOP_MAP;
         loop_code               <= `DILX_RST_LOOP_CODE;
      end else if (wr) begin
         case (paddr)
            `DILX_OFF_IDLE_CODE: begin
               idle_code_sel <= {pwdata[`DILX_IDLE_HI_BIT], pwdata[`DILX_IDLE_LO_BIT]};
            end
            `DILX_OFF_IDLE_SEL: begin
               channel_idle_select_reg <= pwdata[N-1:0];
            end
            `DILX_OFF_LOOP_CODE: begin
               loop_code <= pwdata[7:0];
            end
            `DILX_OFF_LOOP_MAP: begin
               loop_map_reg <= pwdata[N-1:0];
            end
            default: begin
               loop_code <= loop_code;
            end
         endcase
      end
   end

   // APB read data and response
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `DILX_OFF_IDLE_CODE: prdata <= {{30{1'b0}}, idle_code_sel};
               `DILX_OFF_IDLE_SEL:  prdata <= {{28{1'b0}}, channel_idle_select_reg};
               `DILX_OFF_XBIT_STAT: prdata <= {{24{1'b0}}, xbit_word};
               `DILX_OFF_LOOP_CODE: prdata <= {{24{1'b0}}, loop_code};
               `DILX_OFF_LOOP_MAP:  prdata <= {{28{1'b0}}, loop_map_reg};
               default:             prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================
   // Per-channel transmit source mux
   // Select zero takes the channel's own data and clock. Select one
   // sends the idle pattern, unless the loopback map marks the channel,
   // in which case the received signal goes back out instead.
   // Only synchronised copies are read, so a change of select never
   // meets a metastable pin value.
   generate
      for (g = 0; g < N; g = g + 1) begin : g_src
         wire own_d;
         wire own_c;
         wire alt_d;
         wire alt_c;

         // Own transmit leads of this channel
         assign own_d = s2_reg[0][g];
         assign own_c = s2_reg[1][g];

         // Loopback of the received signal, or the idle pattern
         assign alt_d = loop_map_reg[g] ? s2_reg[2][g] : s2_reg[4][g];
         assign alt_c = loop_map_reg[g] ? s2_reg[3][g] : s2_reg[5][g];

         // Idle select picks between the two
         assign dat_next[g] = channel_idle_select_reg[g] ? alt_d : own_d;
         assign clk_next[g] = channel_idle_select_reg[g] ? alt_c : own_c;
      end
   endgenerate

   // ==========================================
   // Registered transmit outputs and X-bit change tracking
   // The overflow flag is set ahead of the clear so that an overflow
   // landing in the clearing cycle is not lost.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ds1_tx_data_out  <= {N{1'b0}};
         ds1_tx_clock_out <= {N{1'b0}};
         xbit_prev_reg    <= 8'h00;
         fifo_overflow    <= 1'b0;
      end else begin
         ds1_tx_data_out  <= dat_next;
         ds1_tx_clock_out <= clk_next;
         xbit_prev_reg    <= xbit_word;
         if ((xbit_word != xbit_prev_reg) & ~xb_in_ready) begin
            fifo_overflow <= 1'b1;
         end else if (wr & (paddr == `DILX_OFF_XBIT_STAT)) begin
            fifo_overflow <= 1'b0;
         end
      end
   end

   // ==========================================
   // Each change of the received X-bits is queued for a reader while the queue is not full
   // Words carry bit 7 as zero; the reader pops with fifo_ready.
   dilx_fifo #(
      .W  (8),
      .D  (`DILX_FIFO_DEPTH),
      .AW (`DILX_FIFO_AW)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_data   (xbit_word),
      .in_valid  (xbit_word != xbit_prev_reg),
      .in_ready  (xb_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );
endmodule
`default_nettype wire

//--- sim/dilx_asserts.sv
// Checker of transmit source select, idle code and X-bit read view
`timescale 1ns/100ps
`default_nettype none
`include "dilx_consts.vh"
module dilx_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [3:0]  ds1_tx_data_in,
   input wire logic [3:0]  ds1_tx_clock_in,
   input wire logic [3:0]  ds1_rx_data_in,
   input wire logic [3:0]  ds1_rx_clock_in,
   input wire logic [3:0]  idle_data_in,
   input wire logic [3:0]  idle_clock_in,
   input wire logic [6:0]  rx_ds2_xbit_in,
   input wire logic [1:0]  idle_code_sel,
   input wire logic [3:0]  ds1_tx_data_out,
   input wire logic [3:0]  ds1_tx_clock_out
);
   logic [3:0] sel, map;
   logic [1:0] code;
   logic [2:0] q, xq;
   wire wr = psel & penable & pwrite & pready;
   wire rd14 = psel & penable & !pwrite & pready & (paddr == `DILX_OFF_XBIT_STAT);
   // Shadow of select registers, cycles since last write and since X-bit change
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel <= 4'h0;
         map <= 4'h0;
         code <= 2'h0;
         q <= 3'h0;
         xq <= 3'h0;
      end else begin
         q <= wr ? 3'h0 : (q == 3'h7 ? q : q + 3'h1);
         xq <= $stable(rx_ds2_xbit_in) ? (xq == 3'h7 ? xq : xq + 3'h1) : 3'h0;
         if (wr && paddr == `DILX_OFF_IDLE_SEL) sel <= pwdata[3:0];
         if (wr && paddr == `DILX_OFF_LOOP_MAP) map <= pwdata[3:0];
         if (wr && paddr == `DILX_OFF_IDLE_CODE) code <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_settled;
      q >= 3'h4;
   endsequence
   AST_SRC_OWN: assert property (s_settled |->
      ((((ds1_tx_data_out ^ $past(ds1_tx_data_in, 3)) |
      (ds1_tx_clock_out ^ $past(ds1_tx_clock_in, 3))) & ~sel) == 4'h0))
      else $error("own source not passed to transmit");
   AST_SRC_IDLE: assert property (s_settled |->
      ((((ds1_tx_data_out ^ $past(idle_data_in, 3)) |
      (ds1_tx_clock_out ^ $past(idle_clock_in, 3))) & sel & ~map) == 4'h0))
      else $error("idle pattern not sent");
   AST_SRC_LOOP: assert property (s_settled |->
      ((((ds1_tx_data_out ^ $past(ds1_rx_data_in, 3)) |
      (ds1_tx_clock_out ^ $past(ds1_rx_clock_in, 3))) & sel & map) == 4'h0))
      else $error("receive signal not looped to transmit");
   AST_IDLE_CODE: assert property (s_settled |-> idle_code_sel == code)
      else $error("idle code select differs from written value");
   AST_XBIT_VIEW: assert property (rd14 && xq >= 3'h5 |-> prdata == {25'h0, rx_ds2_xbit_in})
      else $error("X-bit status differs from received X-bits");
   AST_ANSWER: assert property (s_setup |=> pready)
      else $error("no answer in access cycle");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
endmodule
bind dilx_top dilx_asserts u_chk (.*);
`default_nettype wire

//--- sim/dilx_line_model.sv
// Line interface model: free-running own, received and idle DS1 traffic
`timescale 1ns/100ps
`default_nettype none
module dilx_line_model (
   input  wire logic  pclk,
   output logic [3:0] ds1_tx_data_in,
   output logic [3:0] ds1_tx_clock_in,
   output logic [3:0] ds1_rx_data_in,
   output logic [3:0] ds1_rx_clock_in,
   output logic [3:0] idle_data_in,
   output logic [3:0] idle_clock_in
);
   logic [7:0] c = 8'h00;
   // Distinct patterns per source, so a wrong select shows at once
   always @(posedge pclk) c <= c + 8'h01;
   assign ds1_tx_data_in = c[3:0];
   assign ds1_tx_clock_in = {4{c[0]}};
   assign ds1_rx_data_in = ~c[4:1];
   assign ds1_rx_clock_in = {4{c[1]}};
   assign idle_data_in = c[5:2] ^ 4'h5;
   assign idle_clock_in = ~{4{c[2]}};
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Testbench: registers, source select, X-bit view and X-bit queue
`timescale 1ns/100ps
`default_nettype none
`include "dilx_consts.vh"
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fifo_ready = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, fifo_valid, fifo_overflow, er;
   logic [3:0] ds1_tx_data_in, ds1_tx_clock_in, ds1_rx_data_in, ds1_rx_clock_in;
   logic [3:0] idle_data_in, idle_clock_in, ds1_tx_data_out, ds1_tx_clock_out;
   logic [6:0] rx_ds2_xbit_in = 0;
   logic [1:0] idle_code_sel;
   logic [7:0] loop_code, fifo_data;
   int num_errors = 0, n_compared = 0, cyc = 0;
   dilx_line_model line (.*);
   dilx_top dut (.*);
   initial forever #2.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // APB transfer; holds the request until ready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic t_regs;
      logic [7:0] a [6] = '{8'h08, 8'h38, 8'h78, 8'h3C, 8'h50, 8'h00};
      foreach (a[i]) begin
         apb(0, a[i], 0);
         chk(rd, 0);
         chk(er, i == 5);
      end
      $display("t_regs done");
   endtask
   task automatic t_src;
      logic [3:0] s [4] = '{4'h0, 4'hF, 4'hF, 4'hA};
      logic [3:0] m [4] = '{4'hF, 4'h0, 4'h5, 4'hC};
      logic [3:0] ed, ec;
      for (int i = 0; i < 4; i++) begin
         apb(1, `DILX_OFF_IDLE_CODE, i);
         repeat (2) @(posedge pclk);
         chk(idle_code_sel, i);
      end
      apb(1, `DILX_OFF_LOOP_CODE, 32'h0000_005A);
      apb(0, `DILX_OFF_LOOP_CODE, 0);
      chk(rd, 32'h0000_005A);
      chk(loop_code, 8'h5A);
      for (int i = 0; i < 4; i++) begin
         apb(1, `DILX_OFF_IDLE_SEL, s[i]);
         apb(1, `DILX_OFF_LOOP_MAP, m[i]);
         repeat (12) @(posedge pclk);
         // Sources seen now must reach the transmit outputs three edges later
         ed = (ds1_tx_data_in & ~s[i]) | (ds1_rx_data_in & s[i] & m[i]) | (idle_data_in & s[i] & ~m[i]);
         ec = (ds1_tx_clock_in & ~s[i]) | (ds1_rx_clock_in & s[i] & m[i]) | (idle_clock_in & s[i] & ~m[i]);
         repeat (3) @(posedge pclk);
         chk(ds1_tx_data_out, ed);
         chk(ds1_tx_clock_out, ec);
         apb(0, `DILX_OFF_IDLE_SEL, 0);
         chk(rd, s[i]);
      end
      $display("t_src done");
   endtask
   task automatic t_xbit;
      rx_ds2_xbit_in <= 7'h2A;
      repeat (6) @(posedge pclk);
      apb(0, `DILX_OFF_XBIT_STAT, 0);
      chk(rd & 32'h0000_007F, 32'h0000_002A);
      $display("t_xbit done");
   endtask
   // Fill the queue past full while stalled, then drain in order
   task automatic t_fifo;
      fifo_ready <= 1;
      repeat (20) @(posedge pclk);
      fifo_ready <= 0;
      for (int i = 0; i < 17; i++) begin
         rx_ds2_xbit_in <= 7'h40 + i;
         repeat (4) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      chk(fifo_overflow, 1);
      for (int i = 0; i < 16; i++) begin
         chk(fifo_valid, 1);
         chk(fifo_data, 8'h40 + i);
         fifo_ready <= 1;
         @(posedge pclk);
         fifo_ready <= 0;
         @(posedge pclk);
      end
      chk(fifo_valid, 0);
      apb(1, `DILX_OFF_XBIT_STAT, 0);
      repeat (2) @(posedge pclk);
      chk(fifo_overflow, 0);
      $display("t_fifo done");
   endtask
   task automatic test_done;
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_src;
      t_xbit;
      t_fifo;
      test_done;
   end
endmodule
`default_nettype wire
